// ---- sc_pkg.sv ----
// Shared constants, register map and pin bundles for the card host
package sc_pkg;

    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned SETUP_NS = 70;
    localparam int unsigned STROBE_NS = 165;
    localparam int unsigned RECOVER_NS = 100;
    localparam int unsigned SETUP_CYC =
        (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned STROBE_CYC =
        (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RECOVER_CYC =
        (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_CMD = 8'h08;
    localparam logic [7:0] REG_UDMA = 8'h0C;
    localparam logic [7:0] REG_DATA = 8'h10;
    localparam logic [7:0] REG_STATUS = 8'h14;

    localparam int unsigned CTRL_MODE_LSB = 0;
    localparam int unsigned CTRL_BUS16 = 2;
    localparam int unsigned CTRL_DMA_USED = 3;
    localparam int unsigned CTRL_DRIVE_POSITION_SELECT_DISK = 4;
    localparam int unsigned CTRL_DRIVE_POSITION_SELECT_A25 = 5;
    localparam logic [7:0] CTRL_RESET = 8'h04;

    localparam int unsigned ADDR_ATTR = 11;
    localparam int unsigned ADDR_A25 = 12;

    localparam int unsigned CMD_GO = 0;
    localparam int unsigned CMD_WRITE = 1;
    localparam int unsigned CMD_MEM = 2;

    localparam int unsigned UDMA_ON = 0;
    localparam int unsigned UDMA_READ = 1;
    localparam int unsigned UDMA_STOP = 2;

    localparam logic [1:0] MODE_MEM = 2'h0;
    localparam logic [1:0] MODE_IO = 2'h1;
    localparam logic [1:0] MODE_DISK = 2'h2;

    localparam int unsigned DISK_ADDR_BITS = 3;

    typedef struct packed {
        logic [10:0] addr;
        logic ce1B;
        logic odd_byte_card_enable;
        logic oddByteOe;
        logic outEnB;
        logic memWrB;
        logic io_read_strobe;
        logic io_write_strobe;
        logic drive_position_select;
        logic attrOrGrant;
        logic [15:0] dataOut;
        logic dataOe;
    } sc_card_out_t;

    typedef struct packed {
        logic [15:0] dataIn;
        logic io_ready_out;
        logic input_acknowledge_out;
    } sc_card_in_t;

endpackage

// ---- sc_edge_detect.sv ----
// Edge detector for pin levels already synchronous to the clock
`timescale 1ns/1ps
module sc_edge_detect
    import sc_pkg::*;
#(
    parameter int unsigned WIDTH = 1
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] anyEdge
);
    logic [WIDTH-1:0] prev_ff;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            prev_ff <= '1;
        end else begin
            prev_ff <= level;
        end
    end

    assign anyEdge = prev_ff ^ level;
endmodule

// ---- sc_ahb_slave.sv ----
// AHB-Lite slave front end: zero-wait writes, one-wait reads
`timescale 1ns/1ps
module sc_ahb_slave
    import sc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic regWr,
    output logic regRd,
    output logic [7:0] regAddr,
    output logic [31:0] regWdata,
    input wire logic [31:0] rdData
);
    logic hreadyout_ff;
    logic hresp_ff;
    logic [31:0] hrdata_ff;
    logic wrPend_ff;
    logic rdPend_ff;
    logic [7:0] addr_ff;
    logic addrPhase;

    // Only whole-word transfers are issued; hsize is not decoded
    assign addrPhase = hsel && htrans[1] && hreadyout_ff;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            addr_ff <= 8'h00;
            wrPend_ff <= 1'b0;
        end else begin
            wrPend_ff <= addrPhase && hwrite;
            if (addrPhase) begin
                addr_ff <= {haddr[7:2], 2'b00};
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            hreadyout_ff <= 1'b1;
            rdPend_ff <= 1'b0;
            hrdata_ff <= 32'h0000_0000;
            hresp_ff <= 1'b0;
        end else begin
            hresp_ff <= 1'b0;
            if (rdPend_ff) begin
                hrdata_ff <= rdData;
                hreadyout_ff <= 1'b1;
                rdPend_ff <= 1'b0;
            end else if (addrPhase && !hwrite) begin
                hreadyout_ff <= 1'b0;
                rdPend_ff <= 1'b1;
            end
        end
    end

    assign regWr = wrPend_ff;
    assign regRd = rdPend_ff;
    assign regAddr = addr_ff;
    assign regWdata = hwdata;
    assign hreadyout = hreadyout_ff;
    assign hresp = hresp_ff;
    assign hrdata = hrdata_ff;
endmodule

// ---- sc_card_host.sv ----
// Host-side socket controller driving the shared card connector positions
`timescale 1ns/1ps
module sc_card_host
    import sc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output sc_card_out_t cardOut,
    input wire sc_card_in_t cardIn
);
    typedef enum logic [1:0] {
        PIO_IDLE,
        PIO_SETUP,
        PIO_STROBE,
        PIO_RECOVER
    } sc_pio_state_t;

    logic regWr;
    logic regRd;
    logic [7:0] regAddr;
    logic [31:0] regWdata;
    logic [31:0] rdData;

    logic [7:0] ctrl_ff;
    logic [12:0] addr_ff;
    logic [2:0] udma_ff;
    logic cmdWrite_ff;
    logic cmdMem_ff;
    logic [15:0] dataW_ff;
    logic [15:0] dataR_ff;
    logic [15:0] wordCnt_ff;
    sc_pio_state_t pio_ff;
    logic [3:0] cycCnt_ff;
    logic burstActive_ff;
    logic burstRead_ff;
    logic hstrobe_ff;
    logic txPend_ff;
    logic txArm_ff;
    logic rxFull_ff;
    sc_card_out_t cardOut_ff;
    sc_card_out_t nxt_cardOut;

    logic [1:0] mode;
    logic diskMode;
    logic bus16;
    logic goPulse;
    logic dataWr;
    logic dataRd;
    logic dmaRequest;
    logic deviceReady;
    logic txSend;
    logic strobeEdge;
    logic rxCapture;
    logic armBurst;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        hit = (a == r);
    endfunction

    sc_ahb_slave u_ahb (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .regWr(regWr),
        .regRd(regRd),
        .regAddr(regAddr),
        .regWdata(regWdata),
        .rdData(rdData)
    );

    sc_edge_detect #(
        .WIDTH(1)
    ) u_dstrobe (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .level(cardIn.io_ready_out),
        .anyEdge(strobeEdge)
    );

    assign mode = ctrl_ff[CTRL_MODE_LSB +: 2];
    assign diskMode = (mode == MODE_DISK);
    assign bus16 = ctrl_ff[CTRL_BUS16];
    assign goPulse = regWr && hit(regAddr, REG_CMD) && regWdata[CMD_GO];
    assign dataWr = regWr && hit(regAddr, REG_DATA);
    assign dataRd = regRd && hit(regAddr, REG_DATA);

    // Request is active low on card modes, active high in disk mode
    assign dmaRequest = diskMode ? cardIn.input_acknowledge_out
                                 : !cardIn.input_acknowledge_out;
    // DDMARDY is active low on the ready / hold-off position
    assign deviceReady = !cardIn.io_ready_out;
    assign txSend = burstActive_ff && !burstRead_ff && txPend_ff &&
                    txArm_ff && deviceReady && !udma_ff[UDMA_STOP];
    assign rxCapture = burstActive_ff && burstRead_ff && strobeEdge &&
                       !rxFull_ff;
    assign armBurst = regWr && hit(regAddr, REG_UDMA) &&
                      regWdata[UDMA_ON] && !burstActive_ff;

    // Software-visible configuration
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_ff <= CTRL_RESET;
            addr_ff <= 13'h0000;
            udma_ff <= 3'h0;
        end else if (regWr) begin
            if (hit(regAddr, REG_CTRL) && !burstActive_ff) begin
                ctrl_ff <= regWdata[7:0];
            end else if (hit(regAddr, REG_ADDR)) begin
                addr_ff <= regWdata[12:0];
            end else if (hit(regAddr, REG_UDMA)) begin
                udma_ff <= regWdata[2:0];
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cmdWrite_ff <= 1'b0;
            cmdMem_ff <= 1'b0;
            dataW_ff <= 16'h0000;
        end else begin
            if (goPulse && pio_ff == PIO_IDLE) begin
                cmdWrite_ff <= regWdata[CMD_WRITE];
                cmdMem_ff <= regWdata[CMD_MEM];
            end
            if (dataWr) begin
                dataW_ff <= regWdata[15:0];
            end
        end
    end

    // Programmed cycle sequencer; refused while a burst owns the pins
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pio_ff <= PIO_IDLE;
            cycCnt_ff <= 4'h0;
        end else begin
            case (pio_ff)
                PIO_IDLE: begin
                    if (goPulse && !burstActive_ff) begin
                        pio_ff <= PIO_SETUP;
                        cycCnt_ff <= 4'(SETUP_CYC - 1);
                    end
                end
                PIO_SETUP: begin
                    if (cycCnt_ff == 4'h0) begin
                        pio_ff <= PIO_STROBE;
                        cycCnt_ff <= 4'(STROBE_CYC - 1);
                    end else begin
                        cycCnt_ff <= cycCnt_ff - 4'h1;
                    end
                end
                PIO_STROBE: begin
                    if (cycCnt_ff != 4'h0) begin
                        cycCnt_ff <= cycCnt_ff - 4'h1;
                    end else if (cardIn.io_ready_out) begin
                        pio_ff <= PIO_RECOVER;
                        cycCnt_ff <= 4'(RECOVER_CYC - 1);
                    end
                end
                PIO_RECOVER: begin
                    if (cycCnt_ff == 4'h0) begin
                        pio_ff <= PIO_IDLE;
                    end else begin
                        cycCnt_ff <= cycCnt_ff - 4'h1;
                    end
                end
                default: begin
                    pio_ff <= PIO_IDLE;
                end
            endcase
        end
    end

    // Burst ownership; direction is frozen for the life of a burst
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            burstActive_ff <= 1'b0;
            burstRead_ff <= 1'b0;
        end else if (!burstActive_ff) begin
            if (udma_ff[UDMA_ON] && ctrl_ff[CTRL_DMA_USED] &&
                dmaRequest && pio_ff == PIO_IDLE) begin
                burstActive_ff <= 1'b1;
                burstRead_ff <= udma_ff[UDMA_READ];
            end
        end else if (!udma_ff[UDMA_ON]) begin
            burstActive_ff <= 1'b0;
        end
    end

    // Write burst: a word goes out on each HSTROBE edge
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            txPend_ff <= 1'b0;
            txArm_ff <= 1'b0;
            hstrobe_ff <= 1'b1;
        end else begin
            if (dataWr && burstActive_ff && !burstRead_ff) begin
                txPend_ff <= 1'b1;
            end else if (txSend) begin
                txPend_ff <= 1'b0;
            end
            // Two cycles of data settle ahead of the strobe edge
            txArm_ff <= txPend_ff && !txSend && !dataWr;
            if (txSend) begin
                hstrobe_ff <= !hstrobe_ff;
            end else if (!burstActive_ff) begin
                hstrobe_ff <= 1'b1;
            end
        end
    end

    // Set wins over a same-cycle read; arming a burst drops leftovers
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rxFull_ff <= 1'b0;
            dataR_ff <= 16'h0000;
        end else begin
            if (rxCapture) begin
                rxFull_ff <= 1'b1;
                dataR_ff <= cardIn.dataIn;
            end else if (dataRd || armBurst) begin
                rxFull_ff <= 1'b0;
            end
            if (pio_ff == PIO_STROBE && cycCnt_ff == 4'h0 &&
                cardIn.io_ready_out && !cmdWrite_ff) begin
                // Upper byte is not trusted on an 8 bit socket
                dataR_ff <= bus16 ? cardIn.dataIn
                                  : {8'h00, cardIn.dataIn[7:0]};
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wordCnt_ff <= 16'h0000;
        end else if (armBurst) begin
            wordCnt_ff <= 16'h0000;
        end else if (txSend || rxCapture) begin
            wordCnt_ff <= wordCnt_ff + 16'h0001;
        end
    end

    // Connector position functions from mode, burst state and direction
    always_comb begin
        nxt_cardOut = '0;
        nxt_cardOut.addr = addr_ff[10:0];
        if (diskMode) begin
            nxt_cardOut.addr = {8'h00, addr_ff[DISK_ADDR_BITS-1:0]};
        end
        nxt_cardOut.ce1B = 1'b1;
        nxt_cardOut.odd_byte_card_enable = 1'b1;
        nxt_cardOut.oddByteOe = bus16;
        nxt_cardOut.outEnB = 1'b1;
        nxt_cardOut.memWrB = 1'b1;
        nxt_cardOut.io_read_strobe = 1'b1;
        nxt_cardOut.io_write_strobe = 1'b1;
        if (diskMode) begin
            nxt_cardOut.drive_position_select = ctrl_ff[CTRL_DRIVE_POSITION_SELECT_DISK];
            nxt_cardOut.attrOrGrant = 1'b1;
        end else begin
            nxt_cardOut.drive_position_select =
                ctrl_ff[CTRL_DRIVE_POSITION_SELECT_A25] && addr_ff[ADDR_A25];
            nxt_cardOut.attrOrGrant = !addr_ff[ADDR_ATTR];
        end
        nxt_cardOut.dataOut = dataW_ff;
        nxt_cardOut.dataOe = 1'b0;
        if (burstActive_ff) begin
            nxt_cardOut.attrOrGrant = 1'b0;
            nxt_cardOut.io_write_strobe = udma_ff[UDMA_STOP];
            if (burstRead_ff) begin
                // HDMARDY low while a free slot awaits the next word
                nxt_cardOut.io_read_strobe = rxFull_ff;
            end else begin
                nxt_cardOut.io_read_strobe = hstrobe_ff;
                nxt_cardOut.dataOe = 1'b1;
            end
        end else if (pio_ff != PIO_IDLE) begin
            nxt_cardOut.ce1B = 1'b0;
            nxt_cardOut.odd_byte_card_enable = !bus16;
            nxt_cardOut.dataOe = cmdWrite_ff;
            if (pio_ff == PIO_STROBE) begin
                if (cmdMem_ff && !diskMode) begin
                    nxt_cardOut.memWrB = !cmdWrite_ff;
                    nxt_cardOut.outEnB = cmdWrite_ff;
                end else begin
                    nxt_cardOut.io_write_strobe = !cmdWrite_ff;
                    nxt_cardOut.io_read_strobe = cmdWrite_ff;
                end
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cardOut_ff <= '0;
            cardOut_ff.ce1B <= 1'b1;
            cardOut_ff.odd_byte_card_enable <= 1'b1;
            cardOut_ff.outEnB <= 1'b1;
            cardOut_ff.memWrB <= 1'b1;
            cardOut_ff.io_read_strobe <= 1'b1;
            cardOut_ff.io_write_strobe <= 1'b1;
            cardOut_ff.attrOrGrant <= 1'b1;
        end else begin
            cardOut_ff <= nxt_cardOut;
        end
    end

    assign cardOut = cardOut_ff;

    // Register read mux; unmapped words read as zero
    always_comb begin
        rdData = 32'h0000_0000;
        if (hit(regAddr, REG_CTRL)) begin
            rdData = {24'h00_0000, ctrl_ff};
        end else if (hit(regAddr, REG_ADDR)) begin
            rdData = {19'h0_0000, addr_ff};
        end else if (hit(regAddr, REG_UDMA)) begin
            rdData = {29'h0000_0000, udma_ff};
        end else if (hit(regAddr, REG_DATA)) begin
            rdData = {16'h0000, dataR_ff};
        end else if (hit(regAddr, REG_STATUS)) begin
            rdData = {wordCnt_ff, 8'h00,
                      cardIn.input_acknowledge_out, cardIn.io_ready_out,
                      txPend_ff, rxFull_ff, burstRead_ff, burstActive_ff,
                      1'b0, (pio_ff != PIO_IDLE)};
        end
    end
endmodule

// ---- sc_card_host_props.sv ----
// Port checker for the card host controller
`timescale 1ns/1ps
module sc_card_host_props
    import sc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hreadyout,
    input wire sc_card_out_t cardOut,
    input wire sc_card_in_t cardIn
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);
    // Shadows of the register writes seen on the bus
    logic wrPend_ff;
    logic [7:0] wrAddr_ff;
    logic [7:0] ctrl_ff;
    logic [1:0] adr_ff;
    logic [2:0] udma_ff;
    logic take, disk, burst, reqSeen;
    assign take = hsel && htrans[1] && hreadyout;
    assign disk = ctrl_ff[1:0] == MODE_DISK;
    assign burst = ctrl_ff[CTRL_DMA_USED] && udma_ff[UDMA_ON]
        && !cardOut.attrOrGrant && (disk || !adr_ff[0]);
    assign reqSeen = cardIn.input_acknowledge_out == disk;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wrPend_ff <= 1'b0;
            wrAddr_ff <= 8'h00;
        end else begin
            wrPend_ff <= take && hwrite;
            wrAddr_ff <= haddr[7:0];
        end
    end
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_ff <= CTRL_RESET;
            adr_ff <= 2'h0;
            udma_ff <= 3'h0;
        end else if (wrPend_ff) begin
            if (wrAddr_ff == REG_CTRL)
                ctrl_ff <= hwdata[7:0];
            if (wrAddr_ff == REG_ADDR)
                adr_ff <= hwdata[ADDR_A25:ADDR_ATTR];
            if (wrAddr_ff == REG_UDMA)
                udma_ff <= hwdata[2:0];
        end
    end
    // Pins lag a register write by one cycle, hence the past-write guard
    a_read_wait: assert property (take && !hwrite |=>
        !hreadyout ##1 hreadyout) else $error("read wait");
    a_disk_tieoff: assert property (disk && !$past(wrPend_ff) |->
        cardOut.addr[10:3] == 8'h00 && cardOut.memWrB) else $error("tieoff");
    a_drive_position_select_drive: assert property (!$past(wrPend_ff) |->
        cardOut.drive_position_select == (disk ? ctrl_ff[CTRL_DRIVE_POSITION_SELECT_DISK]
        : ctrl_ff[CTRL_DRIVE_POSITION_SELECT_A25] && adr_ff[1])) else $error("select");
    a_grant_idle: assert property (!ctrl_ff[CTRL_DMA_USED] &&
        !$past(wrPend_ff) |-> cardOut.attrOrGrant == (disk || !adr_ff[0]))
        else $error("grant idle");
    a_odd_float: assert property (!ctrl_ff[CTRL_BUS16] &&
        !$past(wrPend_ff) |-> !cardOut.oddByteOe) else $error("odd oe");
    a_stop_level: assert property (burst && $past(burst) &&
        !$past(wrPend_ff) |-> cardOut.io_write_strobe == udma_ff[UDMA_STOP])
        else $error("stop");
    a_hstrobe_rdy: assert property ($changed(cardOut.io_read_strobe) &&
        burst && $past(burst) && $past(burst, 2) && !udma_ff[UDMA_READ] |->
        $past(!cardIn.io_ready_out) || $past(!cardIn.io_ready_out, 2))
        else $error("hstrobe");
    a_strobe_sel: assert property (!cardOut.io_read_strobe &&
        cardOut.attrOrGrant && $past(cardOut.attrOrGrant) |-> !cardOut.ce1B)
        else $error("strobe select");
    a_req_grant: assert property ($fell(cardOut.attrOrGrant) &&
        ctrl_ff[CTRL_DMA_USED] && !adr_ff[0] && !$past(wrPend_ff) |->
        $past(reqSeen) || $past(reqSeen, 2) || $past(reqSeen, 3))
        else $error("grant");
    c_wr_burst: cover property (burst && !udma_ff[UDMA_READ]);
    c_rd_burst: cover property (burst && udma_ff[UDMA_READ]);
    c_disk_pio: cover property (disk && !cardOut.io_read_strobe);
endmodule

// ---- sc_card_model.sv ----
// Behavioural card answering the host controller's pins
`timescale 1ns/1ps
module sc_card_model
    import sc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [1:0] mode,
    input wire logic reqOn,
    input wire logic rdDir,
    input wire logic slow,
    input wire sc_card_out_t cardOut,
    output sc_card_in_t cardIn,
    output logic [7:0] words
);
    logic [15:0] mem [8];
    logic [15:0] last;
    logic [2:0] cnt;
    logic prevStb;
    logic prevBurst;
    logic dstb;
    logic burst;
    logic wrS;
    logic rdS;
    // Select pin never read; grant only looked at while requesting
    assign burst = reqOn && !cardOut.attrOrGrant;
    assign wrS = !burst && !cardOut.ce1B
        && !(cardOut.memWrB && cardOut.io_write_strobe);
    assign rdS = !burst && !cardOut.ce1B
        && !(cardOut.outEnB && cardOut.io_read_strobe);
    always_comb begin
        // Released data bus shows a changing pattern, not the old word
        cardIn.dataIn = burst ? 16'h5A00 + {8'h00, words} : ~last;
        if (rdS)
            cardIn.dataIn = mem[cardOut.addr[2:0]];
        cardIn.io_ready_out = burst ? rdDir && dstb :
            !(rdS || wrS) || cnt >= (slow ? 3'h4 : 3'h1);
        cardIn.input_acknowledge_out = (mode == MODE_DISK) == reqOn;
    end
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt <= 3'h0;
            words <= 8'h00;
            prevStb <= 1'b1;
            prevBurst <= 1'b0;
            dstb <= 1'b1;
            last <= 16'h0000;
        end else begin
            last <= cardIn.dataIn;
            prevStb <= cardOut.io_read_strobe;
            prevBurst <= burst;
            if (burst)
                cnt <= cnt + 3'h1;
            else if (rdS || wrS)
                cnt <= cnt + {2'h0, cnt != 3'h7};
            else
                cnt <= 3'h0;
            // Upper byte may be undriven on narrow hosts; stored as is
            if (wrS)
                mem[cardOut.addr[2:0]] <= cardOut.dataOut;
            if (!reqOn)
                words <= 8'h00;
            if (!burst)
                dstb <= 1'b1;
            else if (!rdDir && prevBurst && prevStb != cardOut.io_read_strobe)
                words <= words + 8'h01;
            else if (rdDir && cnt[1:0] == 2'h3 && !cardOut.io_read_strobe) begin
                dstb <= !dstb;
                words <= words + 8'h01;
            end
        end
    end
endmodule

// ---- sc_card_host_test.sv ----
// Self-checking bench for the card host controller
`timescale 1ns/1ps
module sc_card_host_test
    import sc_pkg::*;
;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic [31:0] rd;
    sc_card_out_t cardOut;
    sc_card_in_t cardIn;
    logic [1:0] mode = 2'h0;
    logic reqOn = 1'b0;
    logic rdDir = 1'b0;
    logic slow = 1'b0;
    logic [7:0] words;
    int errors = 0;
    int num_checks = 0;
    always #25 core_clk = ~core_clk;
    sc_card_host uut (.core_clk(core_clk), .rst_b(rst_b), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .cardOut(cardOut), .cardIn(cardIn));
    sc_card_model card (.core_clk(core_clk), .rst_b(rst_b), .mode(mode),
        .reqOn(reqOn), .rdDir(rdDir), .slow(slow), .cardOut(cardOut),
        .cardIn(cardIn), .words(words));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
        input string msg);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t %s: %h not %h", $time, msg, seen, exp);
        end
    endtask
    task automatic results();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Negedge value is what the next rising edge samples
    task automatic waitRdy();
        for (int n = 0; n < 50; n++) begin
            @(negedge core_clk);
            if (hreadyout === 1'b1)
                return;
        end
        check(0, 1, "ready timeout");
        results();
    endtask
    task automatic ahb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        waitRdy();
        @(posedge core_clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        waitRdy();
        rd = hrdata;
        @(posedge core_clk);
    endtask
    task automatic poll(input int b, input logic v);
        for (int n = 0; n < 60; n++) begin
            ahb(1'b0, REG_STATUS, 32'h0);
            if (rd[b] === v)
                return;
        end
        check(0, 1, "poll timeout");
        results();
    endtask
    task automatic pio(input logic w, input logic [2:0] i,
        input logic [15:0] d);
        if (w)
            ahb(1'b1, REG_DATA, {16'h0, d});
        ahb(1'b1, REG_ADDR, {29'h2FF, i});
        ahb(1'b1, REG_CMD, {29'h0, mode == MODE_MEM, w, 1'b1});
        poll(0, 1'b0);
        if (!w)
            ahb(1'b0, REG_DATA, 32'h0);
    endtask
    task automatic tReset();
        ahb(1'b0, REG_CTRL, 32'h0);
        check(rd, {24'h0, CTRL_RESET}, "ctrl reset");
        ahb(1'b1, 8'h3C, 32'hFFFF);
        ahb(1'b0, 8'h3C, 32'h0);
        check(rd, 32'h0, "unmapped");
        @(negedge core_clk);
        check({hresp, cardOut.oddByteOe}, 2'h1, "resp, odd oe");
        @(posedge core_clk);
    endtask
    task automatic tPio();
        for (int m = 0; m < 3; m++) begin
            mode <= m[1:0];
            slow <= m == 2;
            ahb(1'b1, REG_CTRL, m == 2 ? 32'h16 : 32'h24 | m);
            pio(1'b1, 3'(m + 4), 16'h1234 + 16'(m));
            pio(1'b0, 3'(m + 4), 16'h0);
            @(negedge core_clk);
            check(rd[15:0], 16'h1234 + 16'(m), "pio data");
            check(cardOut.drive_position_select, 1'b1, "select");
            check({cardOut.attrOrGrant, cardOut.memWrB}, 2'h3, "idle");
            @(posedge core_clk);
        end
    endtask
    task automatic t8bit();
        mode <= MODE_IO;
        slow <= 1'b0;
        ahb(1'b1, REG_CTRL, 32'h01);
        pio(1'b1, 3'h1, 16'hA5C3);
        pio(1'b0, 3'h1, 16'h0);
        @(negedge core_clk);
        check(rd[15:0], 16'h00C3, "byte read");
        check(cardOut.oddByteOe, 1'b0, "odd oe");
        @(posedge core_clk);
    endtask
    task automatic tDma();
        for (int m = 0; m < 3; m++) begin
            for (int r = 0; r < 2; r++) begin
                mode <= m[1:0];
                rdDir <= r[0];
                reqOn <= 1'b1;
                ahb(1'b1, REG_CTRL, 32'h0C | m);
                ahb(1'b1, REG_UDMA, 32'h1 | (r << 1));
                poll(2, 1'b1);
                if (r == 0) begin
                    ahb(1'b1, REG_DATA, 32'hBEEF);
                    poll(5, 1'b0);
                    ahb(1'b1, REG_DATA, 32'hF00D);
                    poll(5, 1'b0);
                    ahb(1'b0, REG_STATUS, 32'h0);
                    check(rd[31:16], 16'h2, "count");
                    check(words, 8'h2, "hstrobe edges");
                end else begin
                    for (int k = 1; k < 3; k++) begin
                        poll(4, 1'b1);
                        ahb(1'b0, REG_DATA, 32'h0);
                        check(rd[15:0], 16'h5A00 + 16'(k), "rx word");
                    end
                end
                ahb(1'b1, REG_UDMA, 32'h5 | (r << 1));
                ahb(1'b0, REG_STATUS, 32'h0);
                @(negedge core_clk);
                check({cardOut.attrOrGrant, cardOut.io_write_strobe}, 2'h1,
                    "stop, grant");
                @(posedge core_clk);
                ahb(1'b1, REG_UDMA, 32'h0);
                reqOn <= 1'b0;
                poll(2, 1'b0);
            end
        end
    endtask
    initial begin
        repeat (3) @(posedge core_clk);
        rst_b <= 1'b1;
        tReset();
        tPio();
        t8bit();
        tDma();
        results();
    end
endmodule
bind sc_card_host sc_card_host_props chk (.core_clk(core_clk),
    .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hreadyout(hreadyout),
    .cardOut(cardOut), .cardIn(cardIn));
